// >>> ctpll_top.v
// Functional notes
// RULE1: root clock chosen by two-bit source field
// RULE2: modulator is root over both dividers, then ratio
// RULE3: dividers seven bits, ratio ten bits split
// RULE4: software enables both dividers before power-up
// RULE5: power-down sequence clocked by running dividers
// RULE6: two read-only power-down flags in status
// RULE7: software disables second then first divider
// RULE8: software disables parents after their children
// RULE9: bit clock pin output divided one to 128
// RULE10: bit clock divider source chosen by mux
// RULE11: general-purpose pin output divided one to 128
// RULE12: general-purpose source chosen by three-bit mux
// RULE13: software keeps clock rates within limits
// RULE14: bit seven turns the pll on
// RULE15: pll output is reference times r times j.d over p
// RULE16: p and r fields, both default one
// RULE17: j six bits, default four
// RULE18: fraction fourteen bits, two registers, default zero
// RULE19: fraction applied when low register written
// RULE20: software keeps integer pll settings in range
// RULE21: software keeps fractional pll reference in range
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`include "ctpll_map.vh"
module ctpll_top #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // clock pins
  input wire mclk_pin,
  input wire bclk_pin_in,
  output reg bclk_pin_out,
  output reg bclk_pin_oe_n,
  input wire gpio_pin_in,
  output reg gpio_pin_out,
  output reg gpio_pin_oe_n,
  // derived clock enables
  output reg root_codec_clock_en,
  output reg dac_clock_en,
  output reg modulator_clock_en,
  output reg sample_rate_en,
  output reg pll_clock_en
);

  // ==========================================
  // helpers
  function [5:0] reg_index;
    input [ADDR_W-1:0] addr;
    begin
      reg_index = addr[7:2];
    end
  endfunction

  function mapped;
    input [5:0] idx;
    begin
      case (idx)
        `CTPLL_IDX_CLK_MUX, `CTPLL_IDX_PLL_PR, `CTPLL_IDX_PLL_J,
        `CTPLL_IDX_FRAC_HI, `CTPLL_IDX_FRAC_LO, `CTPLL_IDX_FIRST_DIV,
        `CTPLL_IDX_SECOND_DIV, `CTPLL_IDX_OSR_HI, `CTPLL_IDX_OSR_LO,
        `CTPLL_IDX_GP_SRC, `CTPLL_IDX_GP_DIV, `CTPLL_IDX_IF_CTRL,
        `CTPLL_IDX_BCLK_MUX, `CTPLL_IDX_BCLK_DIV, `CTPLL_IDX_STATUS,
        `CTPLL_IDX_GPIO_CTRL, `CTPLL_IDX_DAC_PWR:
          mapped = 1'b1;
        default:
          mapped = 1'b0;
      endcase
    end
  endfunction

  // seven-bit field, zero means 128
  function [10:0] ratio7;
    input [6:0] v;
    begin
      ratio7 = (v == 7'h00) ? 11'h080 : {4'h0, v};
    end
  endfunction

  // output divider level, high for the first half of the period
  function level_at;
    input [10:0] cnt;
    input [10:0] ratio;
    input cur;
    begin
      if (ratio == 11'h001)
        level_at = ~cur;
      else
        level_at = (cnt < ((ratio + 11'h001) >> 1));
    end
  endfunction

  // ==========================================
  // pin synchronisers and edge detect
  reg [2:0] pin_meta_reg;
  reg [2:0] pin_sync_reg;
  reg [2:0] pin_last_reg;
  wire [2:0] pin_rise;
  always @(posedge aclk)
  begin
    pin_meta_reg <= {gpio_pin_in, bclk_pin_in, mclk_pin};
    pin_sync_reg <= pin_meta_reg;
    pin_last_reg <= pin_sync_reg;
  end
  assign pin_rise = pin_sync_reg & ~pin_last_reg;

  // ==========================================
  // registers
  reg [7:0] clk_mux_reg;
  reg [7:0] pll_pr_reg;
  reg [7:0] pll_j_reg;
  reg [7:0] frac_hi_reg;
  reg [7:0] frac_lo_reg;
  reg [13:0] frac_live_reg;
  reg [7:0] first_div_reg;
  reg [7:0] second_div_reg;
  reg [7:0] osr_hi_reg;
  reg [7:0] osr_lo_reg;
  reg [7:0] gp_src_reg;
  reg [7:0] gp_div_reg;
  reg [7:0] if_ctrl_reg;
  reg [7:0] bclk_mux_reg;
  reg [7:0] bclk_div_reg;
  reg [7:0] gpio_ctrl_reg;
  reg [7:0] dac_pwr_reg;
  reg flag_hi_reg;
  reg flag_lo_reg;

  // ==========================================
  // axi write path
  reg aw_held_reg;
  reg w_held_reg;
  reg [5:0] aw_idx_reg;
  reg [7:0] w_data_reg;
  reg w_strb_reg;
  wire wr_fire;
  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CTPLL_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_idx_reg <= reg_index(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_idx_reg) ? `CTPLL_RESP_OKAY : `CTPLL_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register writes, status is read-only
  wire wr_en;
  assign wr_en = wr_fire & w_strb_reg;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_mux_reg <= `CTPLL_RST_CLK_MUX;
      pll_pr_reg <= `CTPLL_RST_PLL_PR; // RULE16
      pll_j_reg <= `CTPLL_RST_PLL_J; // RULE17
      frac_hi_reg <= `CTPLL_RST_FRAC;
      frac_lo_reg <= `CTPLL_RST_FRAC;
      frac_live_reg <= 14'h0000; // RULE18
      first_div_reg <= `CTPLL_RST_DIV;
      second_div_reg <= `CTPLL_RST_DIV;
      osr_hi_reg <= `CTPLL_RST_OSR_HI;
      osr_lo_reg <= `CTPLL_RST_OSR_LO;
      gp_src_reg <= `CTPLL_RST_ZERO;
      gp_div_reg <= `CTPLL_RST_DIV;
      if_ctrl_reg <= `CTPLL_RST_ZERO;
      bclk_mux_reg <= `CTPLL_RST_ZERO;
      bclk_div_reg <= `CTPLL_RST_DIV;
      gpio_ctrl_reg <= `CTPLL_RST_ZERO;
      dac_pwr_reg <= `CTPLL_RST_ZERO;
    end
    else if (wr_en)
    begin
      case (aw_idx_reg)
        `CTPLL_IDX_CLK_MUX: clk_mux_reg <= {6'h00, w_data_reg[1:0]};
        `CTPLL_IDX_PLL_PR: pll_pr_reg <= w_data_reg;
        `CTPLL_IDX_PLL_J: pll_j_reg <= {2'b00, w_data_reg[5:0]};
        `CTPLL_IDX_FRAC_HI: frac_hi_reg <= {2'b00, w_data_reg[5:0]};
        `CTPLL_IDX_FRAC_LO:
        begin
          frac_lo_reg <= w_data_reg;
          frac_live_reg <= {frac_hi_reg[5:0], w_data_reg}; // RULE19
        end
        `CTPLL_IDX_FIRST_DIV: first_div_reg <= w_data_reg;
        `CTPLL_IDX_SECOND_DIV: second_div_reg <= w_data_reg;
        `CTPLL_IDX_OSR_HI: osr_hi_reg <= {6'h00, w_data_reg[1:0]};
        `CTPLL_IDX_OSR_LO: osr_lo_reg <= w_data_reg;
        `CTPLL_IDX_GP_SRC: gp_src_reg <= {5'h00, w_data_reg[2:0]};
        `CTPLL_IDX_GP_DIV: gp_div_reg <= {1'b0, w_data_reg[6:0]};
        `CTPLL_IDX_IF_CTRL: if_ctrl_reg <= w_data_reg;
        `CTPLL_IDX_BCLK_MUX: bclk_mux_reg <= {6'h00, w_data_reg[1:0]};
        `CTPLL_IDX_BCLK_DIV: bclk_div_reg <= {1'b0, w_data_reg[6:0]};
        `CTPLL_IDX_GPIO_CTRL: gpio_ctrl_reg <= {7'h00, w_data_reg[0]};
        `CTPLL_IDX_DAC_PWR: dac_pwr_reg <= {w_data_reg[7], 7'h00};
        default: clk_mux_reg <= clk_mux_reg;
      endcase
    end
  end

  // ==========================================
  // axi read path
  reg [7:0] rd_val;
  wire [5:0] rd_idx;
  assign rd_idx = reg_index(s_axi_araddr);
  always @*
  begin
    case (rd_idx)
      `CTPLL_IDX_CLK_MUX: rd_val = clk_mux_reg;
      `CTPLL_IDX_PLL_PR: rd_val = pll_pr_reg;
      `CTPLL_IDX_PLL_J: rd_val = pll_j_reg;
      `CTPLL_IDX_FRAC_HI: rd_val = frac_hi_reg;
      `CTPLL_IDX_FRAC_LO: rd_val = frac_lo_reg;
      `CTPLL_IDX_FIRST_DIV: rd_val = first_div_reg;
      `CTPLL_IDX_SECOND_DIV: rd_val = second_div_reg;
      `CTPLL_IDX_OSR_HI: rd_val = osr_hi_reg;
      `CTPLL_IDX_OSR_LO: rd_val = osr_lo_reg;
      `CTPLL_IDX_GP_SRC: rd_val = gp_src_reg;
      `CTPLL_IDX_GP_DIV: rd_val = gp_div_reg;
      `CTPLL_IDX_IF_CTRL: rd_val = if_ctrl_reg;
      `CTPLL_IDX_BCLK_MUX: rd_val = bclk_mux_reg;
      `CTPLL_IDX_BCLK_DIV: rd_val = bclk_div_reg;
      `CTPLL_IDX_STATUS: rd_val = {flag_hi_reg, 3'b000, flag_lo_reg, 3'b000}; // RULE6
      `CTPLL_IDX_GPIO_CTRL: rd_val = gpio_ctrl_reg;
      `CTPLL_IDX_DAC_PWR: rd_val = dac_pwr_reg;
      default: rd_val = 8'h00;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CTPLL_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_val};
      s_axi_rresp <= mapped(rd_idx) ? `CTPLL_RESP_OKAY : `CTPLL_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================
  // fractional pll as a rate accumulator on the master clock pin
  wire [3:0] pll_p;
  wire [4:0] pll_r;
  wire [23:0] pll_jd;
  wire [23:0] pll_step;
  wire [23:0] pll_thr;
  reg [24:0] pll_acc_reg;
  reg [24:0] pll_acc_next;
  assign pll_p = (pll_pr_reg[6:4] == 3'h0) ? 4'h8 : {1'b0, pll_pr_reg[6:4]}; // RULE16
  assign pll_r = (pll_pr_reg[3:0] == 4'h0) ? 5'h10 : {1'b0, pll_pr_reg[3:0]}; // RULE16
  assign pll_jd = pll_j_reg[5:0] * `CTPLL_FRAC_SCALE + {10'h000, frac_live_reg}; // RULE17
  assign pll_step = pll_r * pll_jd; // RULE15
  assign pll_thr = pll_p * `CTPLL_FRAC_SCALE; // RULE15
  always @*
  begin
    pll_acc_next = pll_acc_reg;
    if (pin_rise[0])
      pll_acc_next = pll_acc_next + {1'b0, pll_step};
    if (pll_acc_next >= {1'b0, pll_thr})
      pll_acc_next = pll_acc_next - {1'b0, pll_thr};
    if (pll_acc_next > {5'h00, pll_thr[16:0], 3'b000})
      pll_acc_next = {5'h00, pll_thr[16:0], 3'b000};
  end
  always @(posedge aclk)
  begin
    if (!aresetn || !pll_pr_reg[`CTPLL_BIT_ENABLE])
    begin
      pll_acc_reg <= 25'h0000000; // RULE14
      pll_clock_en <= 1'b0;
    end
    else
    begin
      pll_acc_reg <= pll_acc_next;
      pll_clock_en <= (pll_acc_reg + (pin_rise[0] ? {1'b0, pll_step} : 25'h0000000))
        >= {1'b0, pll_thr}; // RULE15
    end
  end

  // ==========================================
  // root clock selection
  reg root_en;
  always @*
  begin
    case (clk_mux_reg[1:0]) // RULE1
      2'b00: root_en = pin_rise[0];
      2'b01: root_en = pin_rise[1];
      2'b10: root_en = pin_rise[2];
      default: root_en = pll_clock_en;
    endcase
  end

  // ==========================================
  // cascaded dac dividers: first, second, oversampling
  wire [3:0] stage_in;
  wire [2:0] stage_gate;
  wire [10:0] stage_ratio [0:2];
  reg [10:0] stage_cnt_reg [0:2];
  assign stage_in[0] = root_en;
  assign stage_gate[0] = first_div_reg[`CTPLL_BIT_ENABLE];
  assign stage_gate[1] = second_div_reg[`CTPLL_BIT_ENABLE];
  assign stage_gate[2] = stage_gate[0] & stage_gate[1];
  assign stage_ratio[0] = ratio7(first_div_reg[6:0]); // RULE3
  assign stage_ratio[1] = ratio7(second_div_reg[6:0]); // RULE3
  assign stage_ratio[2] = ({osr_hi_reg[1:0], osr_lo_reg} == 10'h000) ? 11'h400
    : {1'b0, osr_hi_reg[1:0], osr_lo_reg}; // RULE3

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_stage
      assign stage_in[gi+1] = stage_gate[gi] & stage_in[gi]
        & (stage_cnt_reg[gi] == stage_ratio[gi] - 11'h001); // RULE2
      always @(posedge aclk)
      begin
        if (!aresetn || !stage_gate[gi])
          stage_cnt_reg[gi] <= 11'h000;
        else if (stage_in[gi])
          stage_cnt_reg[gi] <= (stage_cnt_reg[gi] >= stage_ratio[gi] - 11'h001)
            ? 11'h000 : stage_cnt_reg[gi] + 11'h001;
      end
    end
  endgenerate

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      root_codec_clock_en <= 1'b0;
      dac_clock_en <= 1'b0;
      modulator_clock_en <= 1'b0;
      sample_rate_en <= 1'b0;
    end
    else
    begin
      root_codec_clock_en <= root_en;
      dac_clock_en <= stage_in[1];
      modulator_clock_en <= stage_in[2]; // RULE2
      sample_rate_en <= stage_in[3]; // RULE2
    end
  end

  // ==========================================
  // dac power-down sequence
  localparam PWR_OFF = 2'd0;
  localparam PWR_ON = 2'd1;
  localparam PWR_DOWN = 2'd2;
  reg [1:0] pwr_state_reg;
  reg [7:0] down_cnt_reg;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwr_state_reg <= PWR_OFF;
      down_cnt_reg <= 8'h00;
      flag_hi_reg <= 1'b1;
      flag_lo_reg <= 1'b1;
    end
    else
    begin
      case (pwr_state_reg)
        PWR_OFF:
          if (dac_pwr_reg[`CTPLL_BIT_ENABLE] && stage_gate[2])
          begin
            pwr_state_reg <= PWR_ON;
            flag_hi_reg <= 1'b0;
            flag_lo_reg <= 1'b0;
          end
        PWR_ON:
          if (!dac_pwr_reg[`CTPLL_BIT_ENABLE])
          begin
            pwr_state_reg <= PWR_DOWN;
            down_cnt_reg <= 8'h00;
          end
        PWR_DOWN:
          if (stage_in[2]) // RULE5
          begin
            down_cnt_reg <= down_cnt_reg + 8'h01;
            if (down_cnt_reg == (`CTPLL_SHUTDOWN_TICKS >> 1))
              flag_lo_reg <= 1'b1; // RULE6
            if (down_cnt_reg == `CTPLL_SHUTDOWN_TICKS - 8'h01)
            begin
              flag_hi_reg <= 1'b1; // RULE6
              pwr_state_reg <= PWR_OFF;
            end
          end
        default:
          pwr_state_reg <= PWR_OFF;
      endcase
    end
  end

  // ==========================================
  // bit clock output divider
  reg bclk_src;
  reg [10:0] bclk_cnt_reg;
  wire [10:0] bclk_ratio;
  wire [10:0] bclk_cnt_next;
  assign bclk_ratio = ratio7(bclk_div_reg[6:0]); // RULE9
  assign bclk_cnt_next = (bclk_cnt_reg >= bclk_ratio - 11'h001) ? 11'h000
    : bclk_cnt_reg + 11'h001;
  always @*
  begin
    case (bclk_mux_reg[1:0]) // RULE10
      2'b00: bclk_src = stage_in[1];
      2'b01: bclk_src = stage_in[2];
      default: bclk_src = 1'b0;
    endcase
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bclk_cnt_reg <= 11'h000;
      bclk_pin_out <= 1'b0;
      bclk_pin_oe_n <= 1'b1;
    end
    else
    begin
      bclk_pin_oe_n <= ~if_ctrl_reg[`CTPLL_BIT_BCLK_DIR]; // RULE9
      if (bclk_src)
      begin
        bclk_cnt_reg <= bclk_cnt_next;
        bclk_pin_out <= level_at(bclk_cnt_next, bclk_ratio, bclk_pin_out); // RULE9
      end
    end
  end

  // ==========================================
  // general-purpose clock output divider
  reg gp_src;
  reg [10:0] gp_cnt_reg;
  wire [10:0] gp_ratio;
  wire [10:0] gp_cnt_next;
  assign gp_ratio = ratio7(gp_div_reg[6:0]); // RULE11
  assign gp_cnt_next = (gp_cnt_reg >= gp_ratio - 11'h001) ? 11'h000 : gp_cnt_reg + 11'h001;
  always @*
  begin
    case (gp_src_reg[2:0]) // RULE12
      3'h0: gp_src = pin_rise[0];
      3'h1: gp_src = pin_rise[1];
      3'h2: gp_src = root_en;
      3'h3: gp_src = stage_in[1];
      3'h4: gp_src = stage_in[2];
      3'h5: gp_src = pll_clock_en;
      default: gp_src = 1'b0;
    endcase
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gp_cnt_reg <= 11'h000;
      gpio_pin_out <= 1'b0;
      gpio_pin_oe_n <= 1'b1;
    end
    else
    begin
      gpio_pin_oe_n <= ~gpio_ctrl_reg[`CTPLL_BIT_GP_OUT]; // RULE11
      if (gp_src)
      begin
        gp_cnt_reg <= gp_cnt_next;
        gpio_pin_out <= level_at(gp_cnt_next, gp_ratio, gpio_pin_out); // RULE11
      end
    end
  end

endmodule

// >>> ctpll_map.vh
`ifndef CTPLL_MAP_VH
`define CTPLL_MAP_VH
// ========
// register indices, byte address is index times four
`define CTPLL_IDX_CLK_MUX 6'h04
`define CTPLL_IDX_PLL_PR 6'h05
`define CTPLL_IDX_PLL_J 6'h06
`define CTPLL_IDX_FRAC_HI 6'h07
`define CTPLL_IDX_FRAC_LO 6'h08
`define CTPLL_IDX_FIRST_DIV 6'h0B
`define CTPLL_IDX_SECOND_DIV 6'h0C
`define CTPLL_IDX_OSR_HI 6'h0D
`define CTPLL_IDX_OSR_LO 6'h0E
`define CTPLL_IDX_GP_SRC 6'h19
`define CTPLL_IDX_GP_DIV 6'h1A
`define CTPLL_IDX_IF_CTRL 6'h1B
`define CTPLL_IDX_BCLK_MUX 6'h1D
`define CTPLL_IDX_BCLK_DIV 6'h1E
`define CTPLL_IDX_STATUS 6'h25
`define CTPLL_IDX_GPIO_CTRL 6'h34
`define CTPLL_IDX_DAC_PWR 6'h3F
// ========
// field positions
`define CTPLL_BIT_ENABLE 7
`define CTPLL_BIT_BCLK_DIR 3
`define CTPLL_BIT_FLAG_HI 7
`define CTPLL_BIT_FLAG_LO 3
`define CTPLL_BIT_GP_OUT 0
// ========
// reset values
`define CTPLL_RST_CLK_MUX 8'h00
`define CTPLL_RST_PLL_PR 8'h11
`define CTPLL_RST_PLL_J 8'h04
`define CTPLL_RST_FRAC 8'h00
`define CTPLL_RST_DIV 8'h01
`define CTPLL_RST_OSR_HI 8'h00
`define CTPLL_RST_OSR_LO 8'h80
`define CTPLL_RST_ZERO 8'h00
// ========
// timing and scaling
`define CTPLL_SHUTDOWN_TICKS 8'h20
`define CTPLL_FRAC_SCALE 24'd10000
// ========
// bus answers
`define CTPLL_RESP_OKAY 2'b00
`define CTPLL_RESP_SLVERR 2'b10
`endif

// >>> ctpll_sva.sv
`include "ctpll_map.vh"
module ctpll_sva_chk #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // clock outputs
  input wire bclk_pin_out,
  input wire bclk_pin_oe_n,
  input wire gpio_pin_oe_n,
  input wire root_codec_clock_en,
  input wire dac_clock_en,
  input wire modulator_clock_en,
  input wire sample_rate_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ========
  // properties
  property p_dac_from_root;
    dac_clock_en |-> root_codec_clock_en;
  endproperty
  property p_mod_from_dac;
    modulator_clock_en |-> dac_clock_en;
  endproperty
  property p_fs_from_mod;
    sample_rate_en |-> modulator_clock_en;
  endproperty
  property p_reset_quiet;
    $rose(aresetn) |-> !root_codec_clock_en && !dac_clock_en && bclk_pin_oe_n && gpio_pin_oe_n;
  endproperty
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  property p_rdata_byte;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  // ========
  // assertions
  a_dac_from_root: assert property (p_dac_from_root)
    else $error("dac enable without root enable");
  a_mod_from_dac: assert property (p_mod_from_dac)
    else $error("modulator enable without dac enable");
  a_fs_from_mod: assert property (p_fs_from_mod)
    else $error("sample enable without modulator enable");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active right after reset");
  a_write_answer: assert property (p_write_answer)
    else $error("write response late");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  a_read_answer: assert property (p_read_answer)
    else $error("read response late");
  a_r_hold: assert property (p_r_hold)
    else $error("read data changed while waiting");
  a_rdata_byte: assert property (p_rdata_byte)
    else $error("read data upper bits not zero");
  // ========
  // coverage
  c_sample: cover property (sample_rate_en);
  c_slverr: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `CTPLL_RESP_SLVERR);
  c_bclk: cover property (!bclk_pin_oe_n && $rose(bclk_pin_out));
endmodule

bind ctpll_top ctpll_sva_chk #(.ADDR_W(ADDR_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .bclk_pin_out(bclk_pin_out), .bclk_pin_oe_n(bclk_pin_oe_n), .gpio_pin_oe_n(gpio_pin_oe_n),
  .root_codec_clock_en(root_codec_clock_en), .dac_clock_en(dac_clock_en),
  .modulator_clock_en(modulator_clock_en), .sample_rate_en(sample_rate_en)
);

// >>> tb_codec_clock_tree_pll.sv
`include "ctpll_map.vh"
module tb_codec_clock_tree_pll;
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // signals
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg [31:0] wdata = 32'h00000000;
  reg [2:0] pins = 3'h0;
  reg bclk_d = 1'b0, gp_d = 1'b0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire bclk_out, bclk_oe_n, gp_out, gp_oe_n, root_en, dac_en, mod_en, fs_en, pll_en;
  integer mismatches = 0;
  integer num_checks = 0;
  integer cycles = 0;
  integer cnt [0:6] = '{0, 0, 0, 0, 0, 0, 0};
  integer base [0:6];
  logic [13:0] rst_tbl [0:12] = '{{6'h04, 8'h00}, {6'h05, 8'h11}, {6'h06, 8'h04},
    {6'h07, 8'h00}, {6'h08, 8'h00}, {6'h0B, 8'h01}, {6'h0C, 8'h01}, {6'h0D, 8'h00},
    {6'h0E, 8'h80}, {6'h19, 8'h00}, {6'h1A, 8'h01}, {6'h1E, 8'h01}, {6'h25, 8'h88}};
  logic [11:0] pll_tbl [0:3] = '{{8'h01, 4'd0}, {8'h91, 4'd4}, {8'hA1, 4'd2}, {8'h92, 4'd6}};

  ctpll_top #(.ADDR_W(8)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mclk_pin(pins[0]), .bclk_pin_in(pins[1]), .bclk_pin_out(bclk_out),
    .bclk_pin_oe_n(bclk_oe_n), .gpio_pin_in(pins[2]), .gpio_pin_out(gp_out),
    .gpio_pin_oe_n(gp_oe_n), .root_codec_clock_en(root_en), .dac_clock_en(dac_en),
    .modulator_clock_en(mod_en), .sample_rate_en(fs_en), .pll_clock_en(pll_en)
  );

  initial
  begin
    forever #2.5 aclk = ~aclk;
  end

  // ========
  // pulse counters and timeout
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    bclk_d <= bclk_out;
    gp_d <= gp_out;
    cnt[0] <= cnt[0] + root_en;
    cnt[1] <= cnt[1] + dac_en;
    cnt[2] <= cnt[2] + mod_en;
    cnt[3] <= cnt[3] + fs_en;
    cnt[4] <= cnt[4] + pll_en;
    cnt[5] <= cnt[5] + (bclk_out & ~bclk_d);
    cnt[6] <= cnt[6] + (gp_out & ~gp_d);
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      close_out;
    end
  end

  // ========
  // helpers
  task automatic chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task automatic wr(input [5:0] idx, input [7:0] d, input [1:0] er);
    reg [1:0] r;
    begin
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      r = 2'b11;
      while (r === 2'b11)
      begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid && bready)
        begin
          r = bresp;
          bready <= 1'b0;
        end
        else if (bvalid) bready <= 1'b1;
      end
      chk(r, er);
    end
  endtask

  task automatic rd(input [5:0] idx, input [7:0] exp, input [1:0] er);
    reg done;
    begin
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      done = 1'b0;
      while (!done)
      begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid && rready)
        begin
          done = 1'b1;
          rready <= 1'b0;
          chk(rdata, {24'h000000, exp});
          chk(rresp, er);
        end
        else if (rvalid) rready <= 1'b1;
      end
    end
  endtask

  task automatic run_pins(input [2:0] m, input integer n);
    begin
      base = cnt;
      repeat (n)
      begin
        @(posedge aclk);
        pins <= m;
        repeat (3) @(posedge aclk);
        pins <= 3'h0;
        repeat (3) @(posedge aclk);
      end
      repeat (12) @(posedge aclk);
    end
  endtask

  task automatic cw(input [5:0] idx, input [7:0] d);
    wr(idx, d, `CTPLL_RESP_OKAY);
  endtask

  // ========
  // scenarios
  task t_regs;
    begin
      for (int i = 0; i < 13; i++) rd(rst_tbl[i][13:8], rst_tbl[i][7:0], `CTPLL_RESP_OKAY);
      wr(6'h00, 8'h55, `CTPLL_RESP_SLVERR);
      rd(6'h00, 8'h00, `CTPLL_RESP_SLVERR);
      cw(`CTPLL_IDX_STATUS, 8'h00);
      rd(`CTPLL_IDX_STATUS, 8'h88, `CTPLL_RESP_OKAY);
      cw(`CTPLL_IDX_PLL_J, 8'h3F);
      rd(`CTPLL_IDX_PLL_J, 8'h3F, `CTPLL_RESP_OKAY);
      cw(`CTPLL_IDX_PLL_J, 8'h04);
    end
  endtask

  task t_mux;
    begin
      for (int s = 0; s < 3; s++)
      begin
        cw(`CTPLL_IDX_CLK_MUX, s[7:0]);
        run_pins(3'h1 << s, 6);
        chk(cnt[0] - base[0], 6);
        run_pins(3'h1 << ((s + 1) % 3), 4);
        chk(cnt[0] - base[0], 0);
      end
      cw(`CTPLL_IDX_CLK_MUX, 8'h00);
    end
  endtask

  task t_div;
    begin
      cw(`CTPLL_IDX_FIRST_DIV, 8'h82);
      cw(`CTPLL_IDX_SECOND_DIV, 8'h83);
      cw(`CTPLL_IDX_OSR_LO, 8'h02);
      cw(`CTPLL_IDX_IF_CTRL, 8'h08);
      cw(`CTPLL_IDX_BCLK_MUX, 8'h00);
      cw(`CTPLL_IDX_BCLK_DIV, 8'h82);
      cw(`CTPLL_IDX_GPIO_CTRL, 8'h01);
      cw(`CTPLL_IDX_GP_SRC, 8'h03);
      cw(`CTPLL_IDX_GP_DIV, 8'h84);
      run_pins(3'h1, 24);
      chk(cnt[1] - base[1], 12);
      chk(cnt[2] - base[2], 4);
      chk(cnt[3] - base[3], 2);
      chk(cnt[5] - base[5], 6);
      chk(cnt[6] - base[6], 4);
      chk(bclk_oe_n, 0);
      chk(gp_oe_n, 0);
      cw(`CTPLL_IDX_BCLK_MUX, 8'h01);
      run_pins(3'h1, 24);
      chk(cnt[5] - base[5], 2);
    end
  endtask

  task t_pwr;
    begin
      cw(`CTPLL_IDX_FIRST_DIV, 8'h81);
      cw(`CTPLL_IDX_SECOND_DIV, 8'h81);
      cw(`CTPLL_IDX_DAC_PWR, 8'h80);
      rd(`CTPLL_IDX_STATUS, 8'h00, `CTPLL_RESP_OKAY);
      cw(`CTPLL_IDX_DAC_PWR, 8'h00);
      run_pins(3'h1, 20);
      rd(`CTPLL_IDX_STATUS, 8'h08, `CTPLL_RESP_OKAY);
      run_pins(3'h1, 16);
      rd(`CTPLL_IDX_STATUS, 8'h88, `CTPLL_RESP_OKAY);
      cw(`CTPLL_IDX_SECOND_DIV, 8'h01);
      cw(`CTPLL_IDX_FIRST_DIV, 8'h01);
      run_pins(3'h1, 4);
      chk(cnt[1] - base[1], 0);
    end
  endtask

  task t_pll;
    begin
      for (int i = 0; i < 4; i++)
      begin
        cw(`CTPLL_IDX_PLL_PR, pll_tbl[i][11:4]);
        cw(`CTPLL_IDX_PLL_J, (i == 3) ? 8'h03 : 8'h04);
        run_pins(3'h1, 8);
        chk(cnt[4] - base[4], 8 * pll_tbl[i][3:0]);
      end
      cw(`CTPLL_IDX_PLL_PR, 8'h91);
      cw(`CTPLL_IDX_PLL_J, 8'h04);
      cw(`CTPLL_IDX_FRAC_HI, 8'h13);
      run_pins(3'h1, 4);
      chk(cnt[4] - base[4], 16);
      cw(`CTPLL_IDX_FRAC_LO, 8'h88);
      run_pins(3'h1, 8);
      chk(cnt[4] - base[4], 36);
      cw(`CTPLL_IDX_PLL_PR, 8'h01);
    end
  endtask

  task close_out;
    begin
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  // ========
  // main sequence
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_mux;
    t_div;
    t_pwr;
    t_pll;
    close_out;
  end
endmodule
